// *** hdl/rgt_pkg.sv ***
// constants for the ringing and ring trip parameter block
package rgt_pkg;
  // parameter memory locations
  localparam logic [7:0] ADDR_RING_DC_OFFSET = 8'h38;
  localparam logic [7:0] ADDR_FREQ_COEF_HIGH = 8'h39;
  localparam logic [7:0] ADDR_FREQ_COEF_LOW = 8'h3a;
  localparam logic [7:0] ADDR_START_PHASE = 8'h3c;
  localparam logic [7:0] ADDR_DC_TRIP_THR = 8'h3e;
  localparam logic [7:0] ADDR_TRIP_FILT_COEF = 8'h3f;
  localparam logic [7:0] ADDR_AC_TRIP_THR = 8'h40;
  localparam logic [7:0] ADDR_DC_TRIP_DB = 8'h41;
  localparam logic [7:0] ADDR_AC_TRIP_DB = 8'h42;
  localparam logic [7:0] ADDR_SETTLE_TIMER = 8'ha8;
  localparam logic [7:0] ADDR_TRIP_STATUS = 8'hc0;
  // field layouts
  localparam logic [15:0] MASK_LOW13 = 16'hfff8;
  localparam logic [15:0] MASK_15BIT = 16'h7fff;
  localparam int ST_AC_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_SETTLE_BIT = 2;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEBOUNCE_STEP_NS = 1250;
  localparam int DEBOUNCE_STEP_CYCLES = (DEBOUNCE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_STEP_US = 1250;
  localparam int SETTLE_FIXED_MS = 60;
  // settle timer states
  typedef enum logic [1:0] {
    SET_IDLE = 2'b01,
    SET_RUN = 2'b10
  } rgt_settle_e;
endpackage : rgt_pkg

// *** hdl/rgt_ring_trip_params.sv ***
// parameter memory, ringing offset, ring trip detection and settle timer
// What this block does
// - low frequency coefficient in location 58 bits 15:3
// - high frequency coefficient in location 57 bits 14:0
// - add 15-bit dc offset while ringing
// - oscillator starts at phase bits 15:3
// - ac detector debounced by location 66
// - ac trip when current exceeds location 64
// - dc debounce counted in 1.25 us steps
// - dc trip when current exceeds location 62
// - location 63 sets trip low-pass coefficient
// - common-mode detectors start settle timer counted in 1.25 ms steps
// - zero settle value means fixed 60 ms
`timescale 1ns/1ps

// one loop current path: low-pass filter, threshold and debounce
module rgt_trip_det (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] sample,
  input wire logic [15:0] coef,
  input wire logic [15:0] threshold,
  input wire logic [15:0] debounce,
  input wire logic stepTick,
  output logic tripLevel
);
  logic [15:0] filt_reg; // filtered loop current
  logic [15:0] cnt_reg; // debounce steps spent above threshold
  logic signed [16:0] diff; // input minus filter state
  logic signed [33:0] prod; // diff scaled by coefficient
  logic above;
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, filt_reg});
  assign prod = diff * $signed({1'b0, coef});
  assign above = filt_reg > threshold;
  // filter moves toward input by coef/65536 each cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) filt_reg <= 16'h0000;
    else filt_reg <= 16'(filt_reg + 16'(prod >>> 16));
  end
  // counter restarts whenever the current drops back
  always_ff @(posedge mclk) begin
    if (!rst_n || !above) cnt_reg <= 16'h0000;
    else if (stepTick && cnt_reg != debounce) cnt_reg <= 16'(cnt_reg + 16'h0001);
  end
  assign tripLevel = above && (cnt_reg == debounce);
endmodule : rgt_trip_det

module rgt_ring_trip_params #(
  parameter int SETTLE_STEP_CYCLES = rgt_pkg::SETTLE_STEP_US * 1000 / rgt_pkg::CLK_PERIOD_NS,
  parameter int SETTLE_FIXED_CYCLES = rgt_pkg::SETTLE_FIXED_MS * 1000000 / rgt_pkg::CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] ramAddr,
  input wire logic [15:0] ramWrData,
  input wire logic ramWr,
  input wire logic ramRd,
  output logic [15:0] ramRdData,
  input wire logic ringMode,
  input wire logic [15:0] ringWave,
  output logic [15:0] ringDrive,
  output logic [27:0] ringFreqCoef,
  output logic [12:0] ringOscStartPhase,
  input wire logic [15:0] acLoopCurrent,
  input wire logic [15:0] dcLoopCurrent,
  output logic acTrip,
  output logic dcTrip,
  input wire logic commonModeHigh,
  input wire logic commonModeLow,
  output logic settleActive
);
  // parameter locations
  logic [15:0] ringDcOffset_reg, freqHigh_reg, freqLow_reg, startPhase_reg;
  logic [15:0] dcThr_reg, filtCoef_reg, acThr_reg, dcDb_reg, acDb_reg, settle_reg;
  logic [1:0] tripSticky_reg; // sticky trip flags, write one to clear
  logic [15:0] rdData_reg, ringDrive_reg;
  logic [6:0] stepCnt_reg; // 1.25 us prescaler
  logic stepTick;
  logic acLvl, dcLvl;
  logic cmPrev_reg; // earlier detector state for edge finding
  logic cmFire;
  logic [31:0] settleCnt_reg, settleLoad;
  rgt_pkg::rgt_settle_e settle_state;
  logic [1:0] clearBits;
  logic [15:0] rdMux;

  // write strobes per location
  wire wrOffset = ramWr && ramAddr == rgt_pkg::ADDR_RING_DC_OFFSET;
  wire wrHigh = ramWr && ramAddr == rgt_pkg::ADDR_FREQ_COEF_HIGH;
  wire wrLow = ramWr && ramAddr == rgt_pkg::ADDR_FREQ_COEF_LOW;
  wire wrPhase = ramWr && ramAddr == rgt_pkg::ADDR_START_PHASE;
  wire wrDcThr = ramWr && ramAddr == rgt_pkg::ADDR_DC_TRIP_THR;
  wire wrCoef = ramWr && ramAddr == rgt_pkg::ADDR_TRIP_FILT_COEF;
  wire wrAcThr = ramWr && ramAddr == rgt_pkg::ADDR_AC_TRIP_THR;
  wire wrDcDb = ramWr && ramAddr == rgt_pkg::ADDR_DC_TRIP_DB;
  wire wrAcDb = ramWr && ramAddr == rgt_pkg::ADDR_AC_TRIP_DB;
  wire wrSettle = ramWr && ramAddr == rgt_pkg::ADDR_SETTLE_TIMER;
  wire wrStatus = ramWr && ramAddr == rgt_pkg::ADDR_TRIP_STATUS;

  // parameter storage; unused low or top bits are never stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ringDcOffset_reg <= rgt_pkg::RESET_VAL;
      freqHigh_reg <= rgt_pkg::RESET_VAL;
      freqLow_reg <= rgt_pkg::RESET_VAL;
      startPhase_reg <= rgt_pkg::RESET_VAL;
      dcThr_reg <= rgt_pkg::RESET_VAL;
      filtCoef_reg <= rgt_pkg::RESET_VAL;
      acThr_reg <= rgt_pkg::RESET_VAL;
      dcDb_reg <= rgt_pkg::RESET_VAL;
      acDb_reg <= rgt_pkg::RESET_VAL;
      settle_reg <= rgt_pkg::RESET_VAL;
    end else begin
      if (wrOffset) ringDcOffset_reg <= ramWrData & rgt_pkg::MASK_15BIT;
      if (wrHigh) freqHigh_reg <= ramWrData & rgt_pkg::MASK_15BIT;
      if (wrLow) freqLow_reg <= ramWrData & rgt_pkg::MASK_LOW13;
      if (wrPhase) startPhase_reg <= ramWrData & rgt_pkg::MASK_LOW13;
      if (wrDcThr) dcThr_reg <= ramWrData;
      if (wrCoef) filtCoef_reg <= ramWrData;
      if (wrAcThr) acThr_reg <= ramWrData;
      if (wrDcDb) dcDb_reg <= ramWrData;
      if (wrAcDb) acDb_reg <= ramWrData;
      if (wrSettle) settle_reg <= ramWrData;
    end
  end

  // read mux; unmapped locations read zero
  always_comb begin
    case (ramAddr)
      rgt_pkg::ADDR_RING_DC_OFFSET: rdMux = ringDcOffset_reg;
      rgt_pkg::ADDR_FREQ_COEF_HIGH: rdMux = freqHigh_reg;
      rgt_pkg::ADDR_FREQ_COEF_LOW: rdMux = freqLow_reg;
      rgt_pkg::ADDR_START_PHASE: rdMux = startPhase_reg;
      rgt_pkg::ADDR_DC_TRIP_THR: rdMux = dcThr_reg;
      rgt_pkg::ADDR_TRIP_FILT_COEF: rdMux = filtCoef_reg;
      rgt_pkg::ADDR_AC_TRIP_THR: rdMux = acThr_reg;
      rgt_pkg::ADDR_DC_TRIP_DB: rdMux = dcDb_reg;
      rgt_pkg::ADDR_AC_TRIP_DB: rdMux = acDb_reg;
      rgt_pkg::ADDR_SETTLE_TIMER: rdMux = settle_reg;
      rgt_pkg::ADDR_TRIP_STATUS: rdMux = {13'h0, settleActive, tripSticky_reg};
      default: rdMux = 16'h0000;
    endcase
  end
  // read data held until the next read
  always_ff @(posedge mclk) begin
    if (!rst_n) rdData_reg <= 16'h0000;
    else if (ramRd) rdData_reg <= rdMux;
  end
  assign ramRdData = rdData_reg;

  // oscillator setup straight from storage
  assign ringFreqCoef = {freqHigh_reg[14:0], freqLow_reg[15:3]};
  assign ringOscStartPhase = startPhase_reg[15:3];

  // offset only applied in ringing mode; sum wraps at 16 bits
  always_ff @(posedge mclk) begin
    if (!rst_n) ringDrive_reg <= 16'h0000;
    else if (ringMode) ringDrive_reg <= 16'(ringWave + ringDcOffset_reg);
    else ringDrive_reg <= ringWave;
  end
  assign ringDrive = ringDrive_reg;

  // shared debounce step for both detectors
  always_ff @(posedge mclk) begin
    if (!rst_n || stepTick) stepCnt_reg <= 7'h00;
    else stepCnt_reg <= 7'(stepCnt_reg + 7'h01);
  end
  assign stepTick = stepCnt_reg == 7'(rgt_pkg::DEBOUNCE_STEP_CYCLES - 1);

  rgt_trip_det acDet (
    .mclk(mclk), .rst_n(rst_n), .sample(acLoopCurrent), .coef(filtCoef_reg),
    .threshold(acThr_reg), .debounce(acDb_reg), .stepTick(stepTick), .tripLevel(acLvl)
  );
  rgt_trip_det dcDet (
    .mclk(mclk), .rst_n(rst_n), .sample(dcLoopCurrent), .coef(filtCoef_reg),
    .threshold(dcThr_reg), .debounce(dcDb_reg), .stepTick(stepTick), .tripLevel(dcLvl)
  );
  assign acTrip = acLvl;
  assign dcTrip = dcLvl;

  // sticky flags; a new trip wins over a clear in the same cycle
  assign clearBits = wrStatus ? ramWrData[1:0] : 2'b00;
  always_ff @(posedge mclk) begin
    if (!rst_n) tripSticky_reg <= 2'b00;
    else tripSticky_reg <= (tripSticky_reg & ~clearBits) | {dcLvl, acLvl};
  end

  // timer restarts on each rising edge of the two detectors ORed together
  assign cmFire = (commonModeHigh || commonModeLow) && !cmPrev_reg;
  assign settleLoad = (settle_reg == 16'h0000) ? 32'(SETTLE_FIXED_CYCLES)
                    : 32'(settle_reg * 32'(SETTLE_STEP_CYCLES));
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmPrev_reg <= 1'b0;
      settleCnt_reg <= 32'h0000_0000;
      settle_state <= rgt_pkg::SET_IDLE;
    end else begin
      cmPrev_reg <= commonModeHigh || commonModeLow;
      case (settle_state)
        rgt_pkg::SET_IDLE: begin
          if (cmFire) begin
            settleCnt_reg <= settleLoad;
            settle_state <= rgt_pkg::SET_RUN;
          end
        end
        rgt_pkg::SET_RUN: begin
          if (cmFire) settleCnt_reg <= settleLoad;
          else if (settleCnt_reg <= 32'h0000_0001) settle_state <= rgt_pkg::SET_IDLE;
          else settleCnt_reg <= settleCnt_reg - 32'h0000_0001;
        end
        default: settle_state <= rgt_pkg::SET_IDLE;
      endcase
    end
  end
  assign settleActive = settle_state == rgt_pkg::SET_RUN;

  // checks
  // scaled load: edge with a nonzero setting, then the running state
  sequence s_cm_edge;
    (cmFire && settle_reg != 16'h0000) ##1 settleActive;
  endsequence
  a_settle_starts: assert property (@(posedge mclk) disable iff (!rst_n)
    cmFire |=> settleActive) else $error("settle timer did not start");
  a_settle_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
    (cmFire && settle_reg == 16'h0000) |=> settleCnt_reg == 32'(SETTLE_FIXED_CYCLES))
    else $error("zero settle value did not load fixed time");
  a_settle_scaled: assert property (@(posedge mclk) disable iff (!rst_n)
    s_cm_edge |-> settleCnt_reg ==
    32'($past(settle_reg) * 32'(SETTLE_STEP_CYCLES))) else $error("settle load wrong");
  a_ring_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    ringMode |=> ringDrive == 16'($past(ringWave) + $past(ringDcOffset_reg)))
    else $error("ringing offset not added");
  a_no_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    !ringMode |=> ringDrive == $past(ringWave)) else $error("offset outside ringing");
  a_freq_low: assert property (@(posedge mclk) disable iff (!rst_n)
    wrLow |=> ringFreqCoef[12:0] == $past(ramWrData[15:3])) else $error("low coef");
  a_freq_high: assert property (@(posedge mclk) disable iff (!rst_n)
    wrHigh |=> ringFreqCoef[27:13] == $past(ramWrData[14:0])) else $error("high coef");
  a_phase_load: assert property (@(posedge mclk) disable iff (!rst_n)
    wrPhase |=> ringOscStartPhase == $past(ramWrData[15:3])) else $error("phase");
  a_trip_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    acLvl |=> tripSticky_reg[rgt_pkg::ST_AC_BIT]) else $error("ac trip not flagged");
  a_dc_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    dcLvl |=> tripSticky_reg[rgt_pkg::ST_DC_BIT]) else $error("dc trip not flagged");
  a_step_period: assert property (@(posedge mclk) disable iff (!rst_n)
    stepTick |=> !stepTick [*5]) else $error("debounce step too short");
endmodule : rgt_ring_trip_params

// *** tb/rgt_loop_model.sv ***
// stand-in for the subscriber loop and linefeed seen by the trip block
`timescale 1ns/1ps
module rgt_loop_model (
  input wire logic mclk,
  input wire logic offHook,
  input wire logic cmHiReq,
  input wire logic cmLoReq,
  output logic [15:0] acLoopCurrent,
  output logic [15:0] dcLoopCurrent,
  output logic commonModeHigh,
  output logic commonModeLow
);
  // on hook still leaves a little leakage, so a zero threshold is not trivial
  always_ff @(posedge mclk) begin
    acLoopCurrent <= offHook ? 16'h0064 : 16'h0003;
    dcLoopCurrent <= offHook ? 16'h0050 : 16'h0002;
    commonModeHigh <= cmHiReq;
    commonModeLow <= cmLoReq;
  end
endmodule : rgt_loop_model

// *** tb/rgt_ring_trip_params_test.sv ***
// self-checking bench for the ringing and ring trip parameter block
`timescale 1ns/1ps
module rgt_ring_trip_params_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ramAddr = 8'h00;
  logic [15:0] ramWrData = 16'h0000;
  logic ramWr = 1'b0;
  logic ramRd = 1'b0;
  logic ringMode = 1'b0;
  logic [15:0] ringWave = 16'h0000;
  logic offHook = 1'b0;
  logic cmHiReq = 1'b0;
  logic cmLoReq = 1'b0;
  logic [15:0] ramRdData, ringDrive, acLoopCurrent, dcLoopCurrent;
  logic [27:0] ringFreqCoef;
  logic [12:0] ringOscStartPhase;
  logic acTrip, dcTrip, commonModeHigh, commonModeLow, settleActive;
  int miscompares = 0;
  int samplesChecked = 0;
  // short settle counts keep the run brief
  rgt_ring_trip_params #(.SETTLE_STEP_CYCLES(10), .SETTLE_FIXED_CYCLES(50))
    rgt_ring_trip_params_i (.mclk(mclk), .rst_n(rst_n), .ramAddr(ramAddr),
    .ramWrData(ramWrData), .ramWr(ramWr), .ramRd(ramRd), .ramRdData(ramRdData),
    .ringMode(ringMode), .ringWave(ringWave), .ringDrive(ringDrive),
    .ringFreqCoef(ringFreqCoef), .ringOscStartPhase(ringOscStartPhase),
    .acLoopCurrent(acLoopCurrent), .dcLoopCurrent(dcLoopCurrent), .acTrip(acTrip),
    .dcTrip(dcTrip), .commonModeHigh(commonModeHigh), .commonModeLow(commonModeLow),
    .settleActive(settleActive));
  rgt_loop_model rgt_loop_model_i (.mclk(mclk), .offHook(offHook), .cmHiReq(cmHiReq),
    .cmLoReq(cmLoReq), .acLoopCurrent(acLoopCurrent), .dcLoopCurrent(dcLoopCurrent),
    .commonModeHigh(commonModeHigh), .commonModeLow(commonModeLow));
  always #10 mclk = ~mclk;
  // shared compare, wide enough for the frequency coefficient
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one write strobe; the leading wait keeps back-to-back strobes apart
  task automatic regWr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    ramAddr = a;
    ramWrData = d;
    ramWr = 1'b1;
    @(negedge mclk);
    ramWr = 1'b0;
  endtask : regWr
  // one read strobe, data is registered at the strobe edge
  task automatic regRd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk);
    ramAddr = a;
    ramRd = 1'b1;
    @(negedge mclk);
    ramRd = 1'b0;
    chk({12'h000, ramRdData}, {12'h000, exp});
  endtask : regRd
  // reset values, field masks, unmapped place and coefficient outputs
  task automatic testRegs();
    regRd(rgt_pkg::ADDR_RING_DC_OFFSET, 16'h0000);
    regRd(rgt_pkg::ADDR_START_PHASE, 16'h0000);
    regWr(rgt_pkg::ADDR_FREQ_COEF_HIGH, 16'hd234);
    regWr(rgt_pkg::ADDR_FREQ_COEF_LOW, 16'habcd);
    regWr(rgt_pkg::ADDR_START_PHASE, 16'h567f);
    regWr(8'h50, 16'hffff);
    regRd(rgt_pkg::ADDR_FREQ_COEF_HIGH, 16'h5234);
    regRd(rgt_pkg::ADDR_FREQ_COEF_LOW, 16'habc8);
    regRd(8'h50, 16'h0000);
    chk(ringFreqCoef, {15'h5234, 13'h1579});
    chk({15'h0000, ringOscStartPhase}, 28'h0000acf);
  endtask : testRegs
  // offset only while ringing, top bit of the offset word ignored
  task automatic testOffset();
    regWr(rgt_pkg::ADDR_RING_DC_OFFSET, 16'hf020);
    regRd(rgt_pkg::ADDR_RING_DC_OFFSET, 16'h7020);
    ringWave = 16'h0100;
    ringMode = 1'b1;
    @(negedge mclk);
    chk({12'h000, ringDrive}, 28'h0007120);
    ringMode = 1'b0;
    @(negedge mclk);
    chk({12'h000, ringDrive}, 28'h0000100);
  endtask : testOffset
  // ac then dc trip, debounce spacing, sticky flag and its clear
  task automatic testTrips();
    int n;
    // thresholds before the coefficient: leakage through a live filter trips at zero
    regWr(rgt_pkg::ADDR_DC_TRIP_THR, 16'hffff);
    regWr(rgt_pkg::ADDR_AC_TRIP_THR, 16'h000a);
    regWr(rgt_pkg::ADDR_AC_TRIP_DB, 16'h0002);
    regWr(rgt_pkg::ADDR_TRIP_FILT_COEF, 16'hffff);
    offHook = 1'b1;
    n = 0;
    // two debounce steps of 63 cycles must pass, the first may be partial
    while (acTrip !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk({27'h0, n >= 64 && n <= 200}, 28'h1);
    regRd(rgt_pkg::ADDR_TRIP_STATUS, 16'h0001);
    offHook = 1'b0;
    repeat (6) @(negedge mclk);
    chk({27'h0, acTrip}, 28'h0);
    regWr(rgt_pkg::ADDR_TRIP_STATUS, 16'h0001);
    regRd(rgt_pkg::ADDR_TRIP_STATUS, 16'h0000);
    regWr(rgt_pkg::ADDR_AC_TRIP_THR, 16'hffff);
    regWr(rgt_pkg::ADDR_DC_TRIP_DB, 16'h0001);
    regWr(rgt_pkg::ADDR_DC_TRIP_THR, 16'h0010);
    offHook = 1'b1;
    n = 0;
    while (dcTrip !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk({27'h0, n >= 2 && n <= 130}, 28'h1);
    regRd(rgt_pkg::ADDR_TRIP_STATUS, 16'h0002);
    offHook = 1'b0;
  endtask : testTrips
  // settle timer length from either detector, zero means the fixed span
  task automatic testSettle(input logic [15:0] v, input int expN, input logic lo);
    int n;
    regWr(rgt_pkg::ADDR_SETTLE_TIMER, v);
    cmHiReq = !lo;
    cmLoReq = lo;
    @(negedge mclk);
    cmHiReq = 1'b0;
    cmLoReq = 1'b0;
    // running timer shows beside the dc flag left from the trip test
    regRd(rgt_pkg::ADDR_TRIP_STATUS, 16'h0006);
    n = 0;
    while (settleActive === 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    // a few cycles of the span are spent before counting starts
    chk({27'h0, n >= expN - 6 && n <= expN + 1}, 28'h1);
  endtask : testSettle
  // verdict in one place for both the normal end and the watchdog
  task automatic tallyAndFinish();
    $display("miscompares %0d samplesChecked %0d", miscompares, samplesChecked);
    if (miscompares == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tallyAndFinish
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    testRegs();
    testOffset();
    testTrips();
    testSettle(16'h0003, 30, 1'b0);
    testSettle(16'h0000, 50, 1'b1);
    tallyAndFinish();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    tallyAndFinish();
  end
endmodule : rgt_ring_trip_params_test
